// file: rtl/pidec_params.svh
// Purpose: constants for the pulse input decoder
// Assumes: apb register map, 20 MHz clock
// Notes:   shared by design, properties and bench
`ifndef PIDEC_PARAMS_SVH
`define PIDEC_PARAMS_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define PIDEC_OFS_ZCFG0   12'h000
`define PIDEC_OFS_ZCFG1   12'h004
`define PIDEC_OFS_SIG0    12'h008
`define PIDEC_OFS_SIG1    12'h00C
`define PIDEC_OFS_AUX0    12'h010
`define PIDEC_OFS_AUX1    12'h014
`define PIDEC_OFS_STAT    12'h018
`define PIDEC_OFS_MASK    12'h01C
`define PIDEC_OFS_CNT0    12'h020
`define PIDEC_OFS_CNT1    12'h024
`define PIDEC_OFS_UPLIM0  12'h028
`define PIDEC_OFS_UPLIM1  12'h02C
`define PIDEC_OFS_LOLIM0  12'h030
`define PIDEC_OFS_LOLIM1  12'h034
`define PIDEC_OFS_PRST0   12'h038
`define PIDEC_OFS_PRST1   12'h03C
`define PIDEC_OFS_CTL     12'h040
// ---------------------------------------------------------------
// codes and reset values
// ---------------------------------------------------------------
`define PIDEC_NIB_ON      4'h1
`define PIDEC_FN_NONE     8'h00
`define PIDEC_FN_PGATE    8'h01
`define PIDEC_FN_NGATE    8'h02
`define PIDEC_FN_PRST_R   8'h03
`define PIDEC_FN_PRST_F   8'h04
`define PIDEC_FN_RST_R    8'h05
`define PIDEC_FN_RST_F    8'h06
`define PIDEC_FN_RST_EN   8'h15
`define PIDEC_FN_RST_DIS  8'h16
`define PIDEC_TGT_C1      8'h01
`define PIDEC_TGT_C2      8'h02
`define PIDEC_UPLIM_RST   32'h7FFF_FFFF
`define PIDEC_LOLIM_RST   32'h8000_0000
`define PIDEC_ZERO32      32'h0000_0000
`define PIDEC_ZERO16      16'h0000
`define PIDEC_CNT_ONE     33'h0_0000_0001
`endif

// file: rtl/pidec_pkg.sv
// Purpose: types for the pulse input decoder
// Assumes: pidec_params.svh defines the constants
// Notes:   none
package pidec_pkg;
    typedef enum logic [15:0] {
        PIDEC_X1    = 16'h0000,
        PIDEC_X2    = 16'h0001,
        PIDEC_X4    = 16'h0002,
        PIDEC_UPDN  = 16'h0004,
        PIDEC_PDIR  = 16'h0008
    } pidec_sig_t;
    typedef struct packed {
        logic a;
        logic b;
        logic z;
    } pidec_enc_t;
    typedef struct packed {
        logic rise;
        logic fall;
        logic lvl;
    } pidec_edge_t;
endpackage

// file: rtl/pidec_top.sv
// Purpose: two-channel counter input decoder with apb registers
// Assumes: i_mclk 20 MHz, synchronous active-high reset
// Notes:   counters are always linear; error code is an event output
`timescale 1ns/1ps
`include "pidec_params.svh"
module pidec_top (
    input  wire logic                 i_mclk,
    input  wire logic                 i_rst,
    input  wire logic                 i_psel,
    input  wire logic                 i_penable,
    input  wire logic                 i_pwrite,
    input  wire logic [11:0]          i_paddr,
    input  wire logic [31:0]          i_pwdata,
    output logic      [31:0]          o_prdata,
    output logic                      o_pready,
    output logic                      o_pslverr,
    input  wire pidec_pkg::pidec_enc_t [1:0] i_enc,
    input  wire logic [1:0]           i_aux,
    output logic      [1:0]           o_err_code,
    output logic                      o_irq
);
    // ---------------------------------------------------------------
    // input synchronisers and edge detection
    // ---------------------------------------------------------------
    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    logic [7:0] sync3_reg;
    logic [7:0] raw;
    pidec_pkg::pidec_edge_t [7:0] ev;
    assign raw = {i_aux, i_enc[1].a, i_enc[1].b, i_enc[1].z,
                  i_enc[0].a, i_enc[0].b, i_enc[0].z};
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            sync1_reg <= 8'h00;
            sync2_reg <= 8'h00;
            sync3_reg <= 8'h00;
        end else begin
            sync1_reg <= raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_edge
            assign ev[gi].rise = sync2_reg[gi] & ~sync3_reg[gi];
            assign ev[gi].fall = ~sync2_reg[gi] & sync3_reg[gi];
            assign ev[gi].lvl  = sync2_reg[gi];
        end
    endgenerate

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [15:0] zcfg_reg [2];
    logic [15:0] sig_reg  [2];
    logic [15:0] aux_reg  [2];
    logic [31:0] uplim_reg [2];
    logic [31:0] lolim_reg [2];
    logic [31:0] prst_reg [2];
    logic [31:0] cnt_reg  [2];
    logic [1:0]  gate_sw_reg;
    logic [1:0]  rst_en_reg;
    logic [1:0]  ext_rst_en_reg;
    logic [3:0]  stat_reg;
    logic [3:0]  mask_reg;
    logic [1:0]  ovf_reg;
    logic [1:0]  udf_reg;
    logic        wr;
    logic        rd;
    assign wr = i_psel & i_penable & i_pwrite;
    assign rd = i_psel & i_penable & ~i_pwrite;
    assign o_pready = 1'b1;
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            zcfg_reg[0]  <= `PIDEC_ZERO16;
            zcfg_reg[1]  <= `PIDEC_ZERO16;
            sig_reg[0]   <= `PIDEC_ZERO16;
            sig_reg[1]   <= `PIDEC_ZERO16;
            aux_reg[0]   <= `PIDEC_ZERO16;
            aux_reg[1]   <= `PIDEC_ZERO16;
            uplim_reg[0] <= `PIDEC_UPLIM_RST;
            uplim_reg[1] <= `PIDEC_UPLIM_RST;
            lolim_reg[0] <= `PIDEC_LOLIM_RST;
            lolim_reg[1] <= `PIDEC_LOLIM_RST;
            prst_reg[0]  <= `PIDEC_ZERO32;
            prst_reg[1]  <= `PIDEC_ZERO32;
            mask_reg     <= 4'h0;
            gate_sw_reg  <= 2'b00;
            rst_en_reg   <= 2'b00;
        end else if (wr) begin
            unique case (i_paddr)
                // bits 15:8 of the z word are held at zero
                `PIDEC_OFS_ZCFG0:  zcfg_reg[0] <= {8'h00, i_pwdata[7:0]};
                `PIDEC_OFS_ZCFG1:  zcfg_reg[1] <= {8'h00, i_pwdata[7:0]};
                `PIDEC_OFS_SIG0:   sig_reg[0]  <= i_pwdata[15:0];
                `PIDEC_OFS_SIG1:   sig_reg[1]  <= i_pwdata[15:0];
                `PIDEC_OFS_AUX0:   aux_reg[0]  <= i_pwdata[15:0];
                `PIDEC_OFS_AUX1:   aux_reg[1]  <= i_pwdata[15:0];
                `PIDEC_OFS_MASK:   mask_reg    <= i_pwdata[3:0];
                `PIDEC_OFS_UPLIM0: uplim_reg[0] <= i_pwdata;
                `PIDEC_OFS_UPLIM1: uplim_reg[1] <= i_pwdata;
                `PIDEC_OFS_LOLIM0: lolim_reg[0] <= i_pwdata;
                `PIDEC_OFS_LOLIM1: lolim_reg[1] <= i_pwdata;
                `PIDEC_OFS_PRST0:  prst_reg[0] <= i_pwdata;
                `PIDEC_OFS_PRST1:  prst_reg[1] <= i_pwdata;
                `PIDEC_OFS_CTL: begin
                    gate_sw_reg <= i_pwdata[1:0];
                    rst_en_reg  <= i_pwdata[3:2];
                end
                default: ;
            endcase
        end
    end
    assign o_pslverr = 1'b0;

    // ---------------------------------------------------------------
    // per-channel decode and count
    // ---------------------------------------------------------------
    logic [1:0] gate_ok;
    logic [1:0] do_prst;
    logic [1:0] do_clr;
    logic [1:0] ext_en_set;
    logic [1:0] ext_en_clr;
    logic [1:0] step_up;
    logic [1:0] step_dn;
    logic [1:0] ovf_ev;
    logic [1:0] udf_ev;
    logic [1:0] dir_reg;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ch
            pidec_pkg::pidec_edge_t ea;
            pidec_pkg::pidec_edge_t eb;
            pidec_pkg::pidec_edge_t ez;
            logic [32:0] nxt;
            logic        up_d;
            logic        dn_d;
            assign ea = ev[3*gi+2];
            assign eb = ev[3*gi+1];
            assign ez = ev[3*gi];
            // aux functions addressed to this channel
            always_comb begin
                gate_ok[gi]    = gate_sw_reg[gi];
                do_prst[gi]    = 1'b0;
                do_clr[gi]     = 1'b0;
                ext_en_set[gi] = 1'b0;
                ext_en_clr[gi] = 1'b0;
                for (int k = 0; k < 2; k++) begin
                    // either input may address either counter
                    if (aux_reg[k][15:8] == 8'(gi + 1)) begin
                        unique case (aux_reg[k][7:0])
                            `PIDEC_FN_PGATE:  gate_ok[gi] = gate_ok[gi] & ev[6+k].lvl;
                            `PIDEC_FN_NGATE:  gate_ok[gi] = gate_ok[gi] & ~ev[6+k].lvl;
                            `PIDEC_FN_PRST_R: do_prst[gi] = do_prst[gi] | ev[6+k].rise;
                            `PIDEC_FN_PRST_F: do_prst[gi] = do_prst[gi] | ev[6+k].fall;
                            `PIDEC_FN_RST_R:  do_clr[gi] = do_clr[gi] | ev[6+k].rise;
                            `PIDEC_FN_RST_F:  do_clr[gi] = do_clr[gi] | ev[6+k].fall;
                            `PIDEC_FN_RST_EN:  ext_en_set[gi] = 1'b1;
                            `PIDEC_FN_RST_DIS: ext_en_clr[gi] = 1'b1;
                            default: ;
                        endcase
                    end
                end
                do_clr[gi] = (do_clr[gi] & rst_en_reg[gi] & ext_rst_en_reg[gi])
                           | (ez.rise & ext_rst_en_reg[gi]
                              & (zcfg_reg[gi][3:0] == `PIDEC_NIB_ON));
            end
            // decoding per signal type
            always_comb begin
                up_d = 1'b0;
                dn_d = 1'b0;
                unique case (pidec_pkg::pidec_sig_t'(sig_reg[gi]))
                    // A leads B: A rises while B low, etc.
                    pidec_pkg::PIDEC_X1: begin
                        up_d = ea.rise & ~eb.lvl;
                        dn_d = ea.fall & ~eb.lvl;
                    end
                    pidec_pkg::PIDEC_X2: begin
                        up_d = (ea.rise & ~eb.lvl) | (ea.fall & eb.lvl);
                        dn_d = (ea.rise & eb.lvl) | (ea.fall & ~eb.lvl);
                    end
                    pidec_pkg::PIDEC_X4: begin
                        up_d = (ea.rise & ~eb.lvl) | (ea.fall & eb.lvl)
                             | (eb.rise & ea.lvl) | (eb.fall & ~ea.lvl);
                        dn_d = (ea.rise & eb.lvl) | (ea.fall & ~eb.lvl)
                             | (eb.rise & ~ea.lvl) | (eb.fall & ea.lvl);
                    end
                    pidec_pkg::PIDEC_UPDN: begin
                        up_d = ea.rise & ~eb.rise;
                        dn_d = eb.rise & ~ea.rise;
                    end
                    pidec_pkg::PIDEC_PDIR: begin
                        up_d = ea.rise & eb.lvl;
                        dn_d = ea.rise & ~eb.lvl;
                    end
                    default: ;
                endcase
                step_up[gi] = up_d & gate_ok[gi];
                step_dn[gi] = dn_d & gate_ok[gi];
            end
            // signed 33-bit next value so limit tests cannot wrap
            assign nxt = step_up[gi] ? ({cnt_reg[gi][31], cnt_reg[gi]} + `PIDEC_CNT_ONE)
                                     : ({cnt_reg[gi][31], cnt_reg[gi]} - `PIDEC_CNT_ONE);
            assign ovf_ev[gi] = step_up[gi] &
                ($signed(nxt) > $signed({uplim_reg[gi][31], uplim_reg[gi]}));
            assign udf_ev[gi] = step_dn[gi] &
                ($signed(nxt) < $signed({lolim_reg[gi][31], lolim_reg[gi]}));
            always_ff @(posedge i_mclk) begin
                if (i_rst) begin
                    cnt_reg[gi]        <= `PIDEC_ZERO32;
                    ovf_reg[gi]        <= 1'b0;
                    udf_reg[gi]        <= 1'b0;
                    dir_reg[gi]        <= 1'b1;
                    ext_rst_en_reg[gi] <= 1'b1;
                    o_err_code[gi]     <= 1'b0;
                end else begin
                    if (ext_en_set[gi])
                        ext_rst_en_reg[gi] <= 1'b1;
                    else if (ext_en_clr[gi])
                        ext_rst_en_reg[gi] <= 1'b0;
                    // counting stops at the limit while flagged
                    if (do_clr[gi]) begin
                        cnt_reg[gi] <= `PIDEC_ZERO32;
                        ovf_reg[gi] <= 1'b0;
                        udf_reg[gi] <= 1'b0;
                    end else if (do_prst[gi]) begin
                        cnt_reg[gi] <= prst_reg[gi];
                        ovf_reg[gi] <= 1'b0;
                        udf_reg[gi] <= 1'b0;
                    end else if (ovf_ev[gi]) begin
                        ovf_reg[gi] <= 1'b1;
                    end else if (udf_ev[gi]) begin
                        udf_reg[gi] <= 1'b1;
                    end else if ((step_up[gi] | step_dn[gi]) & ~ovf_reg[gi] & ~udf_reg[gi]) begin
                        cnt_reg[gi] <= nxt[31:0];
                    end
                    if (step_up[gi] | step_dn[gi])
                        dir_reg[gi] <= step_up[gi];
                    o_err_code[gi] <= (ovf_ev[gi] | udf_ev[gi])
                                    & (zcfg_reg[gi][7:4] == `PIDEC_NIB_ON);
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // sticky status and interrupt
    // ---------------------------------------------------------------
    logic stat_rd;
    assign stat_rd = rd & (i_paddr == `PIDEC_OFS_STAT);
    always_ff @(posedge i_mclk) begin
        if (i_rst)
            stat_reg <= 4'h0;
        else   // clear only what the read returned; a new event wins over the clear
            stat_reg <= (stat_rd ? (stat_reg & ~o_prdata[3:0]) : stat_reg) | {udf_ev, ovf_ev};
    end
    assign o_irq = |(stat_reg & mask_reg);

    // ---------------------------------------------------------------
    // read data
    // ---------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_prdata <= `PIDEC_ZERO32;
        end else if (i_psel & ~i_penable & ~i_pwrite) begin
            unique case (i_paddr)
                `PIDEC_OFS_ZCFG0:  o_prdata <= {16'h0000, zcfg_reg[0]};
                `PIDEC_OFS_ZCFG1:  o_prdata <= {16'h0000, zcfg_reg[1]};
                `PIDEC_OFS_SIG0:   o_prdata <= {16'h0000, sig_reg[0]};
                `PIDEC_OFS_SIG1:   o_prdata <= {16'h0000, sig_reg[1]};
                `PIDEC_OFS_AUX0:   o_prdata <= {16'h0000, aux_reg[0]};
                `PIDEC_OFS_AUX1:   o_prdata <= {16'h0000, aux_reg[1]};
                `PIDEC_OFS_STAT:   o_prdata <= {20'h0_0000, dir_reg, sync2_reg[7:6],
                                                udf_reg, ovf_reg, stat_reg};
                `PIDEC_OFS_MASK:   o_prdata <= {28'h000_0000, mask_reg};
                `PIDEC_OFS_CNT0:   o_prdata <= cnt_reg[0];
                `PIDEC_OFS_CNT1:   o_prdata <= cnt_reg[1];
                `PIDEC_OFS_UPLIM0: o_prdata <= uplim_reg[0];
                `PIDEC_OFS_UPLIM1: o_prdata <= uplim_reg[1];
                `PIDEC_OFS_LOLIM0: o_prdata <= lolim_reg[0];
                `PIDEC_OFS_LOLIM1: o_prdata <= lolim_reg[1];
                `PIDEC_OFS_PRST0:  o_prdata <= prst_reg[0];
                `PIDEC_OFS_PRST1:  o_prdata <= prst_reg[1];
                `PIDEC_OFS_CTL:    o_prdata <= {28'h000_0000, rst_en_reg, gate_sw_reg};
                default:           o_prdata <= `PIDEC_ZERO32;
            endcase
        end
    end
endmodule

// file: sim/pidec_properties.sv
// Purpose: port-level assertions for the pulse input decoder
// Assumes: apb slave answers with pready held high
// Notes:   sees only top ports; config state is inferred from bus traffic
`timescale 1ns/1ps
`include "pidec_params.svh"
module pidec_properties (
    input wire logic        i_mclk,
    input wire logic        i_rst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [1:0]  i_aux,
    input wire logic [31:0] o_prdata,
    input wire logic [1:0]  o_err_code,
    input wire logic        o_irq
);
    // ----------------------------------------------------------
    // sequences and properties
    // ----------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    sequence rd_done;
        i_psel && i_penable && !i_pwrite;
    endsequence
    sequence wr_done;
        i_psel && i_penable && i_pwrite;
    endsequence
    chk_err_one_cycle: assert property ((o_err_code & $past(o_err_code)) == 2'b00)
        else $error("error code pulse longer than one cycle");
    chk_zcfg_top_zero: assert property (rd_done ##0 (i_paddr == `PIDEC_OFS_ZCFG0
        || i_paddr == `PIDEC_OFS_ZCFG1) |-> o_prdata[31:8] == 24'h00_0000)
        else $error("z config upper bits not zero");
    chk_sig_width: assert property (rd_done ##0 (i_paddr == `PIDEC_OFS_SIG0
        || i_paddr == `PIDEC_OFS_SIG1) |-> o_prdata[31:16] == 16'h0000)
        else $error("signal type wider than 16 bits");
    chk_aux_width: assert property (rd_done ##0 (i_paddr == `PIDEC_OFS_AUX0
        || i_paddr == `PIDEC_OFS_AUX1) |-> o_prdata[31:16] == 16'h0000)
        else $error("aux function word wider than 16 bits");
    chk_stat_spare: assert property (rd_done ##0 i_paddr == `PIDEC_OFS_STAT
        |-> o_prdata[31:12] == 20'h0_0000)
        else $error("status spare bits set");
    chk_unmapped_zero: assert property (rd_done ##0 i_paddr > `PIDEC_OFS_CTL
        |-> o_prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_aux_level: assert property ($stable(i_aux)[*4] ##0 rd_done ##0
        i_paddr == `PIDEC_OFS_STAT |-> o_prdata[9:8] == i_aux)
        else $error("aux level not reported");
    chk_prdata_stands: assert property (!(i_psel && !i_penable && !i_pwrite)
        |=> $stable(o_prdata))
        else $error("read data changed without a read");
    chk_irq_masked: assert property (wr_done ##0 i_paddr == `PIDEC_OFS_MASK
        ##0 i_pwdata[3:0] == 4'h0 |=> !o_irq)
        else $error("interrupt high with mask clear");
endmodule
bind pidec_top pidec_properties u_props (.i_mclk(i_mclk), .i_rst(i_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .i_aux(i_aux), .o_prdata(o_prdata), .o_err_code(o_err_code), .o_irq(o_irq));

// file: sim/pidec_enc_model.sv
// Purpose: incremental encoder driving a, b and z of one channel
// Assumes: one quarter step per i_step cycle
// Notes:   steps must be spaced by the caller, the model does not pace itself
`timescale 1ns/1ps
module pidec_enc_model (
    input  wire logic             i_mclk,
    input  wire logic             i_rst,
    input  wire logic             i_step,
    input  wire logic             i_up,
    input  wire logic             i_z,
    output pidec_pkg::pidec_enc_t o_enc
);
    // ----------------------------------------------------------
    // gray phase
    // ----------------------------------------------------------
    logic [1:0] phase_reg;
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            phase_reg <= 2'h0;
        end else if (i_step) begin
            phase_reg <= i_up ? phase_reg + 2'h1 : phase_reg - 2'h1;
        end
    end
    // only one line moves per step, so no edge pair is ever ambiguous
    assign o_enc.a = phase_reg[1] ^ phase_reg[0];
    assign o_enc.b = phase_reg[1];
    assign o_enc.z = i_z;
endmodule

// file: sim/pulse_input_decoder_bench.sv
// Purpose: self-checking bench for the pulse input decoder
// Assumes: apb slave, counts seen 3 edges after an input change
// Notes:   counts after overflow are frozen, so only flags are checked there
`timescale 1ns/1ps
`include "pidec_params.svh"
module pulse_input_decoder_bench;
    logic                        i_mclk = 1'b0;
    logic                        i_rst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_irq;
    logic [11:0]                 i_paddr;
    logic [31:0]                 i_pwdata, o_prdata, rd, seed;
    logic [1:0]                  i_aux, o_err_code, stp, up, zin, gate;
    wire pidec_pkg::pidec_enc_t [1:0] i_enc;
    int                          fails = 0, total_checks = 0, cycles = 0, mode = 0;
    int                          errs[2] = '{0, 0}, mcnt[2] = '{0, 0}, ph[2] = '{0, 0};
    int                          modes[5] = '{0, 1, 2, 4, 8};
    always #25 i_mclk = ~i_mclk;
    pidec_top uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_enc(i_enc), .i_aux(i_aux),
        .o_err_code(o_err_code), .o_irq(o_irq));
    for (genvar c = 0; c < 2; c++) begin : g_enc
        pidec_enc_model u_enc (.i_mclk(i_mclk), .i_rst(i_rst), .i_step(stp[c]), .i_up(up[c]),
            .i_z(zin[c]), .o_enc(i_enc[c]));
    end
    // ----------------------------------------------------------
    // helpers
    // ----------------------------------------------------------
    task summarize();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        for (int c = 0; c < 2; c++) if (o_err_code[c] === 1'b1) errs[c]++;
        if (cycles == 20000) begin
            fails++;
            summarize();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    function automatic int dlt(input int m, input logic a0, b0, a1, b1);
        logic ar, af, x;
        ar = a1 & !a0;
        af = a0 & !a1;
        x = a1 ^ b1;
        case (m)
            0: return ((ar | af) & !b1) ? (ar ? 1 : -1) : 0;
            1: return (ar | af) ? (x ? 1 : -1) : 0;
            2: return (ar | af) ? (x ? 1 : -1) : (b0 ^ b1) ? (x ? -1 : 1) : 0;
            4: return int'(ar) - int'(b1 & !b0);
            8: return ar ? (b1 ? 1 : -1) : 0;
            default: return 0;
        endcase
    endfunction
    task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // request held until pready is seen high at a rising edge
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge i_mclk);
        i_penable <= 1'b1;
        @(posedge i_mclk);
        while (o_pready !== 1'b1) @(posedge i_mclk);
        rd = o_prdata;
        {i_psel, i_penable} <= 2'b00;
    endtask
    task cnt(input int c);
        bus(1'b0, c ? `PIDEC_OFS_CNT1 : `PIDEC_OFS_CNT0, 32'h0000_0000);
    endtask
    task step(input int c, input logic u);
        int p;
        p = (ph[c] + (u ? 1 : 3)) % 4;
        @(posedge i_mclk);
        stp[c] <= 1'b1;
        up[c] <= u;
        @(posedge i_mclk);
        stp[c] <= 1'b0;
        repeat (5) @(posedge i_mclk);
        if (gate[c]) mcnt[c] += dlt(mode, ph[c][1] ^ ph[c][0], ph[c][1], p[1] ^ p[0], p[1]);
        ph[c] = p;
    endtask
    task aux(input int i, input logic v);
        @(posedge i_mclk);
        i_aux[i] <= v;
        repeat (6) @(posedge i_mclk);
    endtask
    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial begin
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
        {i_aux, stp, up, zin, gate} = '0;
        i_rst = 1'b1;
        seed = 32'h0000_17f0;
        repeat (20) @(posedge i_mclk);
        i_rst <= 1'b0;
        bus(1'b0, `PIDEC_OFS_SIG0, 32'h0000_0000);
        check("sig0", rd, 32'h0000_0000);
        bus(1'b0, `PIDEC_OFS_UPLIM0, 32'h0000_0000);
        check("uplim0", rd, `PIDEC_UPLIM_RST);
        bus(1'b0, `PIDEC_OFS_LOLIM1, 32'h0000_0000);
        check("lolim1", rd, `PIDEC_LOLIM_RST);
        bus(1'b1, 12'h0FC, 32'hFFFF_FFFF);
        bus(1'b0, 12'h0FC, 32'h0000_0000);
        check("unmapped", rd, 32'h0000_0000);
        check("pslverr", {31'h0, o_pslverr}, 32'h0000_0000);
        bus(1'b1, `PIDEC_OFS_ZCFG0, 32'hFFFF_FFFF);
        bus(1'b0, `PIDEC_OFS_ZCFG0, 32'h0000_0000);
        check("zcfg0", rd, 32'h0000_00FF);
        bus(1'b1, `PIDEC_OFS_ZCFG0, 32'h0000_0000);
        step(0, 1'b1);
        aux(0, 1'b1);
        bus(1'b0, `PIDEC_OFS_STAT, 32'h0000_0000);
        check("auxlvl", {30'h0, rd[9:8]}, 32'h0000_0001);
        cnt(0);
        check("cnt0 idle", rd, 32'h0000_0000);
        aux(0, 1'b0);
        gate = 2'b11;
        bus(1'b1, `PIDEC_OFS_CTL, 32'h0000_0003);
        foreach (modes[k]) begin
            mode = modes[k];
            bus(1'b1, `PIDEC_OFS_SIG0, mode);
            bus(1'b1, `PIDEC_OFS_SIG1, mode);
            repeat (12) for (int c = 0; c < 2; c++) begin
                seed = xs(seed);
                step(c, seed[0]);
            end
            for (int c = 0; c < 2; c++) begin
                cnt(c);
                check("cnt mode", rd, mcnt[c]);
            end
        end
        // k=0 closed by low level, k=1 open, k=2 inverted gate closed
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, `PIDEC_OFS_AUX0, k == 2 ? 32'h0000_0102 : 32'h0000_0101);
            aux(0, k != 0);
            gate[0] = (k == 1);
            repeat (3) step(0, 1'b1);
            cnt(0);
            check("cnt gate", rd, mcnt[0]);
        end
        bus(1'b1, `PIDEC_OFS_AUX0, 32'h0000_0000);
        gate[0] = 1'b1;
        bus(1'b1, `PIDEC_OFS_PRST0, 32'h0000_0064);
        bus(1'b1, `PIDEC_OFS_AUX1, 32'h0000_0103);
        aux(1, 1'b1);
        mcnt[0] = 100;
        bus(1'b1, `PIDEC_OFS_PRST1, 32'h0000_0007);
        bus(1'b1, `PIDEC_OFS_AUX1, 32'h0000_0204);
        aux(1, 1'b0);
        mcnt[1] = 7;
        for (int c = 0; c < 2; c++) begin
            cnt(c);
            check("cnt preset", rd, mcnt[c]);
        end
        bus(1'b1, `PIDEC_OFS_CTL, 32'h0000_000F);
        bus(1'b1, `PIDEC_OFS_AUX0, 32'h0000_0116);
        bus(1'b1, `PIDEC_OFS_AUX1, 32'h0000_0105);
        aux(1, 1'b1);
        cnt(0);
        check("cnt reset off", rd, mcnt[0]);
        bus(1'b1, `PIDEC_OFS_AUX0, 32'h0000_0115);
        bus(1'b1, `PIDEC_OFS_AUX1, 32'h0000_0106);
        aux(1, 1'b0);
        mcnt[0] = 0;
        cnt(0);
        check("cnt reset fall", rd, mcnt[0]);
        repeat (3) step(0, 1'b1);
        bus(1'b1, `PIDEC_OFS_AUX1, 32'h0000_0105);
        aux(1, 1'b1);
        mcnt[0] = 0;
        cnt(0);
        check("cnt reset rise", rd, mcnt[0]);
        repeat (3) step(0, 1'b1);
        bus(1'b1, `PIDEC_OFS_ZCFG0, 32'h0000_0001);
        @(posedge i_mclk);
        zin[0] <= 1'b1;
        repeat (6) @(posedge i_mclk);
        zin[0] <= 1'b0;
        mcnt[0] = 0;
        cnt(0);
        check("cnt z reset", rd, mcnt[0]);
        mode = 2;
        bus(1'b1, `PIDEC_OFS_SIG0, mode);
        bus(1'b1, `PIDEC_OFS_SIG1, mode);
        bus(1'b1, `PIDEC_OFS_MASK, 32'h0000_0000);
        bus(1'b1, `PIDEC_OFS_UPLIM0, mcnt[0] + 2);
        bus(1'b1, `PIDEC_OFS_ZCFG0, 32'h0000_0010);
        repeat (3) step(0, 1'b1);
        check("irq masked", {31'h0, o_irq}, 32'h0000_0000);
        bus(1'b0, `PIDEC_OFS_STAT, 32'h0000_0000);
        check("stat ovf", {24'h0, rd[7:0]}, 32'h0000_0011);
        check("err ch1", errs[0], 32'h0000_0001);
        bus(1'b1, `PIDEC_OFS_MASK, 32'h0000_0008);
        bus(1'b1, `PIDEC_OFS_LOLIM1, mcnt[1] - 2);
        repeat (3) step(1, 1'b0);
        check("irq udf", {31'h0, o_irq}, 32'h0000_0001);
        bus(1'b0, `PIDEC_OFS_STAT, 32'h0000_0000);
        check("stat udf", {20'h0, rd[11:0]}, 32'h0000_0798);
        @(posedge i_mclk);
        check("irq cleared", {31'h0, o_irq}, 32'h0000_0000);
        check("err ch2", errs[1], 32'h0000_0000);
        summarize();
    end
endmodule
